// File: hdl/msm_stop_selector.sv
`timescale 1ns/100ps
module msm_stop_selector #(
   parameter bit LARGE_RATING = 1'b0
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic alarm_class_one_i,
   input wire logic alarm_class_two_i,
   input wire logic main_power_ok_i,
   input wire logic control_power_ok_i,
   input wire logic motor_stopped_i,
   output logic power_enable_o,
   output logic dyn_brake_o,
   output logic zero_speed_ref_o,
   output logic zero_pos_clamp_o,
   output logic torque_limit_en_o,
   output logic [9:0] torque_limit_o,
   output logic decel_ramp_en_o,
   output logic [13:0] decel_time_ms_o
);
   import msm_pkg::*;

   // ==========================================================
   // Register storage
   logic [3:0] c1_wr_reg, dec_wr_reg, c2_wr_reg;
   logic [3:0] class_one_stop_select, class_two_decel_select, class_two_stop_class_select;
   logic load_pending_reg;
   logic [9:0] emergency_stop_torque_limit;
   logic [9:0] motor_max_torque_reg;
   logic [13:0] stop_decel_time;
   logic servo_on_reg;
   logic restart_reg;
   msm_state_t state_reg, state_next;
   msm_method_t method_reg, method_next;
   msm_after_t after_reg, after_next;

   wire logic setup_ph = psel_i && !penable_i;
   wire logic wr_en = psel_i && penable_i && pready_o && pwrite_i;

   // ==========================================================
   // APB slave: answers in the access phase, no wait states
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end else begin
         pready_o <= setup_ph;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         if (setup_ph) begin
            case (paddr_i)
               MSM_CFG_OFF: prdata_o <= {20'h00000, c2_wr_reg, dec_wr_reg, c1_wr_reg};
               MSM_TRQ_OFF: prdata_o <= {22'h000000, emergency_stop_torque_limit};
               MSM_DECEL_OFF: prdata_o <= {18'h00000, stop_decel_time};
               MSM_CTRL_OFF: prdata_o <= {31'h00000000, servo_on_reg};
               MSM_STAT_OFF: prdata_o <= {12'h000, class_two_stop_class_select,
                  class_two_decel_select, class_one_stop_select, 1'b0,
                  after_reg, method_reg, state_reg};
               MSM_MAXTRQ_OFF: prdata_o <= {22'h000000, motor_max_torque_reg};
               default: pslverr_o <= 1'b1;
            endcase
         end
      end
   end

   // ==========================================================
   // Writable registers
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         c1_wr_reg <= MSM_SEL_RST;
         dec_wr_reg <= MSM_SEL_RST;
         c2_wr_reg <= MSM_SEL_RST;
         emergency_stop_torque_limit <= MSM_TRQ_RST;
         stop_decel_time <= MSM_DECEL_RST;
         motor_max_torque_reg <= MSM_MAXTRQ_RST;
         servo_on_reg <= 1'b0;
         restart_reg <= 1'b0;
      end else begin
         restart_reg <= 1'b0;
         if (wr_en) begin
            case (paddr_i)
               MSM_CFG_OFF: begin
                  c1_wr_reg <= pwdata_i[MSM_C1_LSB +: 4];
                  dec_wr_reg <= pwdata_i[MSM_DEC_LSB +: 4];
                  c2_wr_reg <= pwdata_i[MSM_C2_LSB +: 4];
               end
               MSM_TRQ_OFF: begin
                  if (pwdata_i[9:0] > MSM_TRQ_MAX || pwdata_i[31:10] != 22'h000000) begin
                     emergency_stop_torque_limit <= MSM_TRQ_MAX;
                  end else begin
                     emergency_stop_torque_limit <= pwdata_i[9:0];
                  end
               end
               MSM_DECEL_OFF: begin
                  if (pwdata_i[13:0] > MSM_DECEL_MAX || pwdata_i[31:14] != 18'h00000) begin
                     stop_decel_time <= MSM_DECEL_MAX;
                  end else begin
                     stop_decel_time <= pwdata_i[13:0];
                  end
               end
               MSM_CTRL_OFF: begin
                  servo_on_reg <= pwdata_i[MSM_CTRL_SERVO_BIT];
                  restart_reg <= pwdata_i[MSM_CTRL_RESTART_BIT];
               end
               MSM_MAXTRQ_OFF: motor_max_torque_reg <= pwdata_i[9:0];
               default: ;
            endcase
         end
      end
   end

   // ==========================================================
   // Active selects, loaded only after reset or a restart command
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         load_pending_reg <= 1'b1;
         class_one_stop_select <= MSM_SEL_RST;
         class_two_decel_select <= MSM_SEL_RST;
         class_two_stop_class_select <= MSM_SEL_RST;
      end else begin
         load_pending_reg <= restart_reg;
         if (load_pending_reg) begin
            class_one_stop_select <= c1_wr_reg;
            class_two_decel_select <= dec_wr_reg;
            class_two_stop_class_select <= c2_wr_reg;
         end
      end
   end

   // ==========================================================
   // Method selection
   function automatic logic [4:0] msm_class_one(input logic [3:0] c1);
      begin
         case (c1)
            4'h1: msm_class_one = {MSM_M_BRAKE, MSM_A_COAST};
            4'h2: msm_class_one = {MSM_M_COAST, MSM_A_COAST};
            default: msm_class_one = {MSM_M_BRAKE, MSM_A_BRAKE};
         endcase
      end
   endfunction : msm_class_one

   function automatic logic [4:0] msm_class_two(input logic [3:0] c1, input logic [3:0] dec,
                                                input logic [3:0] c2, input logic zero_time);
      msm_after_t aft;
      begin
         aft = MSM_A_COAST;
         case (c2)
            4'h0: begin
               aft = (c1 == 4'h0) ? MSM_A_BRAKE : MSM_A_COAST;
               msm_class_two = {MSM_M_ZERO, aft};
            end
            4'h2: begin
               case (dec)
                  4'h1, 4'h2: begin
                     aft = (dec == 4'h1 && c1 == 4'h0) ? MSM_A_BRAKE : MSM_A_COAST;
                     msm_class_two = {MSM_M_TORQUE, aft};
                  end
                  4'h3, 4'h4: begin
                     aft = (dec == 4'h3 && c1 == 4'h0) ? MSM_A_BRAKE : MSM_A_COAST;
                     if (zero_time) begin
                        msm_class_two = {MSM_M_ZERO, aft};
                     end else begin
                        msm_class_two = {MSM_M_DECEL, aft};
                     end
                  end
                  default: msm_class_two = msm_class_one(c1);
               endcase
            end
            default: msm_class_two = msm_class_one(c1);
         endcase
      end
   endfunction : msm_class_two

   wire logic ctrl_loss = !control_power_ok_i;
   wire logic main_loss = !main_power_ok_i;
   wire logic hard_stop = ctrl_loss || main_loss || alarm_class_one_i;
   wire logic any_stop = hard_stop || alarm_class_two_i || !servo_on_reg;

   // ==========================================================
   // Stop sequencer
   always_comb begin
      logic [4:0] sel;
      sel = msm_class_one(class_one_stop_select);
      if (ctrl_loss) begin
         sel = LARGE_RATING ? {MSM_M_COAST, MSM_A_COAST}
                            : {MSM_M_BRAKE, MSM_A_BRAKE};
      end else if (main_loss) begin
         sel = {MSM_M_BRAKE, MSM_A_BRAKE};
      end else if (!alarm_class_one_i && alarm_class_two_i) begin
         sel = msm_class_two(class_one_stop_select, class_two_decel_select,
                             class_two_stop_class_select, stop_decel_time == 14'h0000);
      end
      state_next = state_reg;
      method_next = method_reg;
      after_next = after_reg;
      case (state_reg)
         MSM_RUN: begin
            if (any_stop) begin
               state_next = MSM_STOP;
               method_next = msm_method_t'(sel[4:2]);
               after_next = msm_after_t'(sel[1:0]);
            end
         end
         MSM_STOP: begin
            if (hard_stop && method_reg != MSM_M_BRAKE && method_reg != MSM_M_COAST) begin
               method_next = msm_method_t'(sel[4:2]);
               after_next = msm_after_t'(sel[1:0]);
            end else if (method_reg == MSM_M_COAST || motor_stopped_i) begin
               state_next = MSM_DONE;
            end
         end
         MSM_DONE: begin
            if (!any_stop) begin
               state_next = MSM_RUN;
            end
         end
         default: state_next = MSM_RUN;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= MSM_DONE;
         method_reg <= MSM_M_BRAKE;
         after_reg <= MSM_A_BRAKE;
      end else begin
         state_reg <= state_next;
         method_reg <= method_next;
         after_reg <= after_next;
      end
   end

   // ==========================================================
   // Power stage commands
   wire logic stop_n = (state_next == MSM_STOP);
   wire logic done_n = (state_next == MSM_DONE);
   wire logic [9:0] eff_torque = (emergency_stop_torque_limit > motor_max_torque_reg)
                                 ? motor_max_torque_reg : emergency_stop_torque_limit;
   // Motor at rest on the last cycle of a zero-speed STOP: close the position loop on the next cycle, the first of DONE
   wire logic zclamp = (state_reg == MSM_STOP) && (method_reg == MSM_M_ZERO) && motor_stopped_i;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         power_enable_o <= 1'b0;
         dyn_brake_o <= 1'b1;
         zero_speed_ref_o <= 1'b0;
         zero_pos_clamp_o <= 1'b0;
         torque_limit_en_o <= 1'b0;
         torque_limit_o <= 10'h000;
         decel_ramp_en_o <= 1'b0;
         decel_time_ms_o <= 14'h0000;
      end else begin
         power_enable_o <= (state_next == MSM_RUN)
            || (stop_n && (method_next == MSM_M_ZERO || method_next == MSM_M_TORQUE
                           || method_next == MSM_M_DECEL));
         dyn_brake_o <= (stop_n && method_next == MSM_M_BRAKE)
            || (done_n && after_next == MSM_A_BRAKE);
         zero_speed_ref_o <= (stop_n && method_next == MSM_M_ZERO) || zclamp;
         zero_pos_clamp_o <= zclamp;
         torque_limit_en_o <= stop_n && method_next == MSM_M_TORQUE;
         torque_limit_o <= eff_torque;
         decel_ramp_en_o <= stop_n && method_next == MSM_M_DECEL;
         decel_time_ms_o <= stop_decel_time;
      end
   end

   // ==========================================================
   // Checks
   sequence run_to_stop_s;
      state_reg == MSM_RUN && !hard_stop && !alarm_class_two_i
         && class_one_stop_select == 4'h0 ##1 state_reg == MSM_STOP;
   endsequence

   sequence zero_hold_s;
      state_reg == MSM_STOP && method_reg == MSM_M_ZERO && motor_stopped_i;
   endsequence

   servo_off_brake_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      run_to_stop_s |-> dyn_brake_o)
      else $error("servo off with select 0 did not brake");

   coast_no_power_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (state_reg == MSM_DONE && after_reg == MSM_A_COAST) |-> (!power_enable_o && !dyn_brake_o))
      else $error("coasting state still drives the motor");

   zero_stop_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (state_reg == MSM_RUN && !hard_stop && alarm_class_two_i && servo_on_reg
         && class_two_stop_class_select == 4'h0)
      |=> (method_reg == MSM_M_ZERO && zero_speed_ref_o && power_enable_o))
      else $error("class-two default did not pick zero-speed stop");

   class_one_alarm_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (state_reg == MSM_RUN && alarm_class_one_i && !main_loss && !ctrl_loss
         && class_one_stop_select == 4'h2) |=> (method_reg == MSM_M_COAST))
      else $error("class-one alarm ignored the class-one select");

   main_loss_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (state_reg == MSM_RUN && main_loss && control_power_ok_i) |=> ##1 dyn_brake_o)
      else $error("main power loss did not brake");

   torque_cap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      torque_limit_o <= MSM_TRQ_MAX && torque_limit_o <= $past(motor_max_torque_reg))
      else $error("torque limit above cap");

   restart_only_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!load_pending_reg) |=> $stable(class_one_stop_select))
      else $error("stop select changed without restart");

   clamp_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      zero_pos_clamp_o |-> zero_speed_ref_o)
      else $error("position clamp without zero speed reference");

   decel_stop_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (state_reg == MSM_STOP && method_reg == MSM_M_DECEL) |-> (decel_ramp_en_o
         && decel_time_ms_o != 14'h0000))
      else $error("timed stop without ramp or with zero time");

   clamp_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      zero_hold_s |=> (zero_pos_clamp_o && zero_speed_ref_o))
      else $error("stopped zero-speed stop did not clamp position");

   ctrl_loss_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (state_reg == MSM_RUN && ctrl_loss)
      |=> (method_reg == (LARGE_RATING ? MSM_M_COAST : MSM_M_BRAKE)))
      else $error("control power loss picked the wrong method");

   torque_stop_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (state_reg == MSM_STOP && method_reg == MSM_M_TORQUE)
      |-> (torque_limit_en_o && power_enable_o))
      else $error("torque-limited stop without limit or power");

   class_two_one_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (state_reg == MSM_RUN && !hard_stop && alarm_class_two_i && servo_on_reg
         && class_two_stop_class_select == 4'h1 && class_one_stop_select == 4'h2)
      |=> (method_reg == MSM_M_COAST))
      else $error("class-two alarm at stop class 1 not handled as class one");

   apb_ready_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (psel_i && !penable_i) |=> pready_o)
      else $error("access phase without ready");

endmodule : msm_stop_selector

// File: hdl/msm_pkg.sv
// Behaviour
// - Servo off stops per class-one select: 0 brake, 1 brake then coast, 2 coast.
// - A class-one alarm stops exactly as servo off does.
// - Class-two alarm method comes from three select fields together; defaults give zero clamp.
// - Stop class 0: zero-speed stop, then brake if class-one select 0, else coast.
// - Stop class 1: class-two alarm handled exactly like a class-one alarm.
// - Stop class 2 with decel select 0: brake or coast per class-one select.
// - Decel select 1 or 2: torque-limited stop; brake only if 1 and class-one 0.
// - Decel select 3 or 4: timed stop; brake only if 3 and class-one 0.
// - Zero clamp forces speed reference to zero, then holds position at zero reference; zero_pos_clamp_o is high for one cycle only, once the motor stops.
// - Coasting leaves the motor wholly uncontrolled.
// - Main power loss brakes; control power loss brakes small units, coasts large ones.
// - Emergency torque limit 0 to 800 percent, default 800, capped at motor maximum.
// - Stop decel time 0 to 10000 ms in 1 ms steps; zero means zero-speed stop.
package msm_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] MSM_CFG_OFF = 8'h00;
   localparam logic [7:0] MSM_TRQ_OFF = 8'h04;
   localparam logic [7:0] MSM_DECEL_OFF = 8'h08;
   localparam logic [7:0] MSM_CTRL_OFF = 8'h0c;
   localparam logic [7:0] MSM_STAT_OFF = 8'h10;
   localparam logic [7:0] MSM_MAXTRQ_OFF = 8'h14;
   // ==========================================================
   // Field positions
   localparam int MSM_C1_LSB = 0;
   localparam int MSM_DEC_LSB = 4;
   localparam int MSM_C2_LSB = 8;
   localparam int MSM_CTRL_SERVO_BIT = 0;
   localparam int MSM_CTRL_RESTART_BIT = 1;
   // ==========================================================
   // Reset values and limits
   localparam logic [3:0] MSM_SEL_RST = 4'h0;
   localparam logic [9:0] MSM_TRQ_MAX = 10'h320;
   localparam logic [9:0] MSM_TRQ_RST = 10'h320;
   localparam logic [13:0] MSM_DECEL_MAX = 14'h2710;
   localparam logic [13:0] MSM_DECEL_RST = 14'h0000;
   localparam logic [9:0] MSM_MAXTRQ_RST = 10'h12c;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {MSM_RUN, MSM_STOP, MSM_DONE} msm_state_t;
   typedef enum logic [2:0] {
      MSM_M_BRAKE, MSM_M_COAST, MSM_M_ZERO, MSM_M_TORQUE, MSM_M_DECEL
   } msm_method_t;
   typedef enum logic [1:0] {MSM_A_BRAKE, MSM_A_COAST, MSM_A_CLAMP} msm_after_t;
endpackage : msm_pkg

// File: tb/msm_motor_model.sv
`timescale 1ns/100ps
// ====================
// Motor and power stage
module msm_motor_model #(
   parameter int STOP_CYCLES = 12
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic slow_i,
   input wire logic power_enable_i,
   input wire logic zero_speed_ref_i,
   input wire logic torque_limit_en_i,
   input wire logic decel_ramp_en_i,
   output logic motor_stopped_o
);
   int cnt;
   logic tick;
   // Spins while driven freely, winds down otherwise; slow halves the rate
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt <= 0;
         tick <= 1'b0;
      end else begin
         tick <= ~tick;
         if (power_enable_i && !zero_speed_ref_i && !torque_limit_en_i && !decel_ramp_en_i) begin
            cnt <= STOP_CYCLES;
         end else if (cnt > 0 && (!slow_i || tick)) begin
            cnt <= cnt - 1;
         end
      end
   end
   assign motor_stopped_o = (cnt == 0);
endmodule : msm_motor_model

// File: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
   import msm_pkg::*;
   logic clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e, slow_i;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, q;
   logic alarm_class_one_i, alarm_class_two_i, main_power_ok_i, control_power_ok_i;
   logic motor_stopped_i, power_enable_o, dyn_brake_o, zero_speed_ref_o, zero_pos_clamp_o;
   logic torque_limit_en_o, decel_ramp_en_o;
   logic [9:0] torque_limit_o;
   logic [13:0] decel_time_ms_o, decel_val;
   int n_errors, samples_checked;
   // ====================
   // Design and motor
   msm_stop_selector #(.LARGE_RATING(1'b0)) DUT (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .alarm_class_one_i(alarm_class_one_i),
      .alarm_class_two_i(alarm_class_two_i), .main_power_ok_i(main_power_ok_i),
      .control_power_ok_i(control_power_ok_i), .motor_stopped_i(motor_stopped_i),
      .power_enable_o(power_enable_o), .dyn_brake_o(dyn_brake_o),
      .zero_speed_ref_o(zero_speed_ref_o), .zero_pos_clamp_o(zero_pos_clamp_o),
      .torque_limit_en_o(torque_limit_en_o), .torque_limit_o(torque_limit_o),
      .decel_ramp_en_o(decel_ramp_en_o), .decel_time_ms_o(decel_time_ms_o));
   msm_motor_model #(.STOP_CYCLES(12)) motor (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow_i), .power_enable_i(power_enable_o),
      .zero_speed_ref_i(zero_speed_ref_o), .torque_limit_en_i(torque_limit_en_o),
      .decel_ramp_en_i(decel_ramp_en_o), .motor_stopped_o(motor_stopped_i));
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // ====================
   // Helpers
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      samples_checked++;
      if (s !== x) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, x, s);
      end
   endtask : chk
   task automatic finish_test;
      if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : finish_test
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      q = prdata_o;
      e = pslverr_o;
      chk("pready", 32'(pready_o), 32'h1);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rd
   task automatic set_cause(input int c);
      alarm_class_one_i <= (c == 1);
      alarm_class_two_i <= (c == 2);
      main_power_ok_i <= (c != 3);
      control_power_ok_i <= (c != 4);
   endtask : set_cause
   function automatic logic [4:0] expect_stop(input int cause, input logic [3:0] c1, dec, c2,
         input logic zt);
      msm_method_t m;
      msm_after_t a;
      m = (c1 == 4'h2) ? MSM_M_COAST : MSM_M_BRAKE;
      a = (c1 == 4'h0) ? MSM_A_BRAKE : MSM_A_COAST;
      if (cause >= 3) begin
         m = MSM_M_BRAKE;
         a = MSM_A_BRAKE;
      end else if (cause == 2 && c2 == 4'h0) begin
         m = MSM_M_ZERO;
      end else if (cause == 2 && c2 == 4'h2 && dec != 4'h0) begin
         m = (dec < 4'h3) ? MSM_M_TORQUE : (zt ? MSM_M_ZERO : MSM_M_DECEL);
         a = ((dec == 4'h1 || dec == 4'h3) && c1 == 4'h0) ? MSM_A_BRAKE : MSM_A_COAST;
      end
      return {m, a};
   endfunction : expect_stop
   task automatic stop_case(input int cause, input logic [3:0] c1, dec, c2, input bit late);
      logic [4:0] x;
      int n;
      x = expect_stop(cause, c1, dec, c2, decel_val == 14'h0);
      wr(MSM_CFG_OFF, {20'h0, c2, dec, c1});
      wr(MSM_CTRL_OFF, 32'h2);
      wr(MSM_CTRL_OFF, 32'h1);
      if (late) wr(MSM_CFG_OFF, 32'h102);
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (power_enable_o !== 1'b1 && n < 80);
      chk("run_power", 32'(power_enable_o), 32'h1);
      @(posedge clk_i);
      if (cause == 0) wr(MSM_CTRL_OFF, 32'h0); // Host stops by command
      set_cause(cause);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      case (x[4:2])
         MSM_M_BRAKE: chk("brake_on", 32'(dyn_brake_o), 32'h1);
         MSM_M_COAST: chk("coast_free", 32'({power_enable_o, dyn_brake_o}), 32'h0);
         MSM_M_ZERO: chk("zero_ref", 32'({power_enable_o, zero_speed_ref_o}), 32'h3);
         MSM_M_TORQUE: chk("trq_lim", 32'({torque_limit_en_o, torque_limit_o}), 32'h52c);
         default: chk("ramp", 32'({decel_ramp_en_o, decel_time_ms_o}), 32'h4032);
      endcase
      if (x[4:2] == MSM_M_ZERO) begin
         n = 0;
         while (motor_stopped_i !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
         end
         @(negedge clk_i);
         chk("pos_clamp", 32'(zero_pos_clamp_o), 32'h1);
      end
      @(posedge clk_i);
      n = 0;
      do begin
         rd(MSM_STAT_OFF);
         n++;
      end while (q[1:0] !== 2'h2 && n < 60);
      chk("method", 32'(q[4:2]), 32'(x[4:2]));
      chk("after", 32'(q[6:5]), 32'(x[1:0]));
      @(negedge clk_i);
      chk("final_brake", 32'(dyn_brake_o), 32'(x[1:0] == MSM_A_BRAKE));
      chk("final_power", 32'(power_enable_o), 32'h0);
      @(posedge clk_i);
      set_cause(0);
   endtask : stop_case
   // ====================
   // Scenarios
   task automatic test_regs;
      rd(MSM_TRQ_OFF);
      chk("trq_rst", q, 32'h320);
      rd(MSM_DECEL_OFF);
      chk("decel_rst", q, 32'h0);
      wr(MSM_TRQ_OFF, 32'd900);
      rd(MSM_TRQ_OFF);
      chk("trq_clamp", q, 32'h320);
      wr(MSM_DECEL_OFF, 32'd20000);
      rd(MSM_DECEL_OFF);
      chk("decel_clamp", q, 32'h2710);
      wr(MSM_DECEL_OFF, 32'd50);
      decel_val = 14'd50;
      rd(MSM_MAXTRQ_OFF);
      chk("maxtrq_rst", q, 32'h12c);
      rd(8'h18);
      chk("unmapped", {q[30:0], e}, 32'h1);
   endtask : test_regs
   task automatic test_stop_sources;
      for (int c1 = 0; c1 < 3; c1++) begin
         stop_case(0, 4'(c1), 4'h0, 4'h0, 1'b0);
         stop_case(1, 4'(c1), 4'h0, 4'h0, 1'b0);
      end
      stop_case(3, 4'h0, 4'h0, 4'h0, 1'b0);
      stop_case(4, 4'h1, 4'h0, 4'h0, 1'b0);
      stop_case(2, 4'h0, 4'h0, 4'h0, 1'b1);
   endtask : test_stop_sources
   task automatic test_alarm_two;
      for (int c2 = 0; c2 < 3; c2++) begin
         for (int dec = 0; dec < 5; dec++) begin
            for (int c1 = 0; c1 < 3; c1++) begin
               if (c2 == 2 || dec == 0) begin
                  slow_i <= c1[0];
                  stop_case(2, 4'(c1), 4'(dec), 4'(c2), 1'b0);
               end
            end
         end
      end
      stop_case(2, 4'h0, 4'h0, 4'h1, 1'b0); // Coupled axes set to brake on alarms
      wr(MSM_DECEL_OFF, 32'h0);
      decel_val = 14'h0;
      stop_case(2, 4'h0, 4'h3, 4'h2, 1'b0);
   endtask : test_alarm_two
   initial begin
      n_errors = 0;
      samples_checked = 0;
      decel_val = 14'h0;
      sys_rst_i = 1'b1;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 8'h00;
      pwdata_i = 32'h0;
      slow_i = 1'b0;
      alarm_class_one_i = 1'b0;
      alarm_class_two_i = 1'b0;
      main_power_ok_i = 1'b1;
      control_power_ok_i = 1'b1;
      repeat (20) @(posedge clk_i);
      @(negedge clk_i);
      chk("rst_out", 32'({dyn_brake_o, power_enable_o}), 32'h2);
      @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      test_regs;
      test_stop_sources;
      test_alarm_two;
      finish_test;
   end
   initial begin
      #400000;
      n_errors++;
      finish_test;
   end
endmodule : testbench
